// File: logic/bdts_lowest_set.sv
// lowest set bit finder of the remaining register list.
// assumes the caller checks found_o before using index_o.
`timescale 1ns/1ps
module bdts_lowest_set
  import bdts_pkg::*;
#(
  parameter int unsigned WIDTH = BDTS_RLIST_W,
  parameter int unsigned IDX_W = BDTS_IDX_W
)
(
  input  wire logic [WIDTH-1:0] mask_i,   // remaining selection
  output logic      [IDX_W-1:0] index_o,  // lowest selected index
  output logic                  found_o   // any bit set
);

  // scan from the top so the lowest set bit wins
  always_comb
  begin
    index_o = '0;
    found_o = 1'b0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (mask_i[i])
      begin
        index_o = IDX_W'(i);
        found_o = 1'b1;
      end
    end
  end

endmodule // bdts_lowest_set

// File: logic/bdts_pkg.sv
// package for the block data transfer sequencer: instruction field
// positions, address step, store offset of the program counter, states.
// assumes a 32-bit core with sixteen visible registers.
package bdts_pkg;

  localparam int unsigned BDTS_WORD_W   = 32;   // data and address width
  localparam int unsigned BDTS_RLIST_W  = 16;   // register list width
  localparam int unsigned BDTS_IDX_W    = 4;    // register index width
  localparam int unsigned BDTS_COND_HI  = 31;   // condition field top
  localparam int unsigned BDTS_COND_LO  = 28;   // condition field bottom
  localparam int unsigned BDTS_PRE_BIT  = 24;   // 1 = offset before transfer
  localparam int unsigned BDTS_UP_BIT   = 23;   // 1 = add offset
  localparam int unsigned BDTS_S_BIT    = 22;   // status restore / user bank
  localparam int unsigned BDTS_WB_BIT   = 21;   // 1 = write address to base
  localparam int unsigned BDTS_LOAD_BIT = 20;   // 1 = load, 0 = store
  localparam int unsigned BDTS_BASE_HI  = 19;   // base index field top
  localparam int unsigned BDTS_BASE_LO  = 16;   // base index field bottom

  localparam logic [3:0]  BDTS_PC_IDX     = 4'hF;          // program counter
  localparam logic [31:0] BDTS_WORD_STEP  = 32'h00000004;  // bytes per word
  localparam logic [31:0] BDTS_PC_STORE   = 32'h0000000C;  // stored pc offset
  localparam logic [15:0] BDTS_RLIST_RST  = 16'h0000;      // list reset value
  localparam logic [31:0] BDTS_WORD_RST   = 32'h00000000;  // word reset value

  // gray coded along idle-addr-xfer-last-fill1-fill2
  typedef enum logic [2:0] {
    BDTS_IDLE  = 3'h0,
    BDTS_ADDR  = 3'h1,
    BDTS_XFER  = 3'h3,
    BDTS_LAST  = 3'h2,
    BDTS_FILL1 = 3'h6,
    BDTS_FILL2 = 3'h7
  } bdts_state_type;

endpackage : bdts_pkg

// File: logic/bdts_sequencer.sv
// block data transfer sequencer: multi_load and multi_store execution.
// assumes a register file with a same-cycle read port and a write port
// whose value is visible from the next cycle, a memory that answers each
// transfer in its own cycle, and an outside condition evaluator.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module bdts_sequencer
  import bdts_pkg::*;
(
  input  wire logic        CLK_SYS_I,          // core clock, 10 MHz
  input  wire logic        RSTN_I,             // async reset, active low
  input  wire logic        INSTR_VALID_I,      // instruction offered
  input  wire logic [31:0] INSTR_I,            // block transfer instruction
  input  wire logic [31:0] INSTR_ADDR_I,       // address of instruction
  output logic      [3:0]  COND_FIELD_O,       // field to the evaluator
  input  wire logic        COND_PASS_I,        // condition holds
  output logic             BUSY_O,             // instruction in progress
  output logic             DONE_O,             // pulse, instruction ended
  output logic             DATA_ABORT_O,       // pulse, enter abort trap
  output logic             STATUS_RESTORE_O,   // pulse, saved to current
  output logic      [3:0]  REG_RD_IDX_O,       // register read index
  output logic             REG_RD_USER_O,      // read from user bank
  input  wire logic [31:0] REG_RD_DATA_I,      // register read data
  output logic             REG_WR_EN_O,        // register write strobe
  output logic      [3:0]  REG_WR_IDX_O,       // register write index
  output logic             REG_WR_USER_O,      // write into user bank
  output logic      [31:0] REG_WR_DATA_O,      // register write data
  output logic             MEM_REQ_O,          // memory transfer cycle
  output logic             MEM_WRITE_O,        // 1 = write
  output logic             MEM_SEQ_O,          // sequential cycle
  output logic      [31:0] MEM_ADDR_O,         // transfer address
  output logic      [31:0] MEM_WDATA_O,        // store data
  input  wire logic [31:0] MEM_RDATA_I,        // load data
  input  wire logic        MEM_ABORT_I         // abort for this transfer
);

  bdts_state_type state, next_state;
  logic [15:0] rlist, next_rlist;        // registers still to move
  logic [3:0]  base_idx, next_base_idx;
  logic [31:0] base_val, next_base_val;
  logic [31:0] wb_val, next_wb_val;
  logic [31:0] addr, next_addr;
  logic [31:0] instr_pc, next_instr_pc;
  logic [31:0] wdata, next_wdata;
  logic [31:0] ld_data, next_ld_data;
  logic [3:0]  ld_idx, next_ld_idx;
  logic [3:0]  xfer_idx, next_xfer_idx;
  logic        ld_pend, next_ld_pend;
  logic        is_load, next_is_load;
  logic        wb, next_wb;
  logic        s_bit, next_s_bit;
  logic        pc_in, next_pc_in;
  logic        base_in, next_base_in;
  logic        first, next_first;
  logic        aborted, next_aborted;
  logic        done, next_done;
  logic        trap, next_trap;
  logic [3:0]  low_idx;
  logic        low_found;
  logic [31:0] n_bytes;
  logic        user_bank;

  bdts_lowest_set #(
    .WIDTH (BDTS_RLIST_W),
    .IDX_W (BDTS_IDX_W)
  ) u_lowest (
    .mask_i  (rlist),
    .index_o (low_idx),
    .found_o (low_found)
  );

  // byte span of the list: four per selected register
  always_comb
  begin
    n_bytes = '0;
    for (int i = 0; i < BDTS_RLIST_W; i++)
    begin
      if (INSTR_I[i])
      begin
        n_bytes = n_bytes + BDTS_WORD_STEP;
      end
    end
  end

  // user bank when bit 22 is set, unless a load brings back the program counter
  assign user_bank = s_bit && !(is_load && pc_in);

  assign COND_FIELD_O = INSTR_I[BDTS_COND_HI:BDTS_COND_LO];
  assign BUSY_O       = (state != BDTS_IDLE);
  assign DONE_O       = done;
  assign DATA_ABORT_O = trap;
  assign MEM_REQ_O    = (state == BDTS_XFER);
  assign MEM_WRITE_O  = (state == BDTS_XFER) && !is_load;
  assign MEM_SEQ_O    = (state == BDTS_XFER) && !first;
  assign MEM_ADDR_O   = addr;
  assign MEM_WDATA_O  = wdata;

  // read port: base while idle, next register to store otherwise
  always_comb
  begin
    REG_RD_IDX_O  = (state == BDTS_IDLE) ?
                    INSTR_I[BDTS_BASE_HI:BDTS_BASE_LO] : low_idx;
    REG_RD_USER_O = (state != BDTS_IDLE) && user_bank;
  end

  // write port: base update in cycle two, loads one cycle late
  always_comb
  begin
    REG_WR_EN_O      = 1'b0;
    REG_WR_IDX_O     = ld_idx;
    REG_WR_USER_O    = 1'b0;
    REG_WR_DATA_O    = ld_data;
    STATUS_RESTORE_O = 1'b0;
    if (state == BDTS_XFER && first && wb)
    begin
      REG_WR_EN_O   = 1'b1;
      REG_WR_IDX_O  = base_idx;
      REG_WR_DATA_O = wb_val;
    end
    else if ((state == BDTS_XFER || state == BDTS_LAST) && ld_pend)
    begin
      REG_WR_EN_O      = 1'b1;
      REG_WR_USER_O    = user_bank;
      STATUS_RESTORE_O = s_bit && (ld_idx == BDTS_PC_IDX);
    end
    else if (state == BDTS_LAST && aborted && base_in)
    begin
      REG_WR_EN_O   = 1'b1;
      REG_WR_IDX_O  = base_idx;
      REG_WR_DATA_O = wb ? wb_val : base_val;
    end
  end

  // sequencing of address, transfer, internal and refill cycles
  always_comb
  begin
    next_state    = state;
    next_rlist    = rlist;
    next_base_idx = base_idx;
    next_base_val = base_val;
    next_wb_val   = wb_val;
    next_addr     = addr;
    next_instr_pc = instr_pc;
    next_wdata    = wdata;
    next_ld_data  = ld_data;
    next_ld_idx   = ld_idx;
    next_xfer_idx = xfer_idx;
    next_ld_pend  = 1'b0;
    next_is_load  = is_load;
    next_wb       = wb;
    next_s_bit    = s_bit;
    next_pc_in    = pc_in;
    next_base_in  = base_in;
    next_first    = first;
    next_aborted  = aborted;
    next_done     = 1'b0;
    next_trap     = 1'b0;
    case (state)
      BDTS_IDLE:
      begin
        if (INSTR_VALID_I && !COND_PASS_I)
        begin
          next_done = 1'b1;
        end
        else if (INSTR_VALID_I && INSTR_I[15:0] == BDTS_RLIST_RST)
        begin
          next_done = 1'b1;
        end
        else if (INSTR_VALID_I)
        begin
          next_state    = BDTS_ADDR;
          next_rlist    = INSTR_I[15:0];
          next_base_idx = INSTR_I[BDTS_BASE_HI:BDTS_BASE_LO];
          next_base_val = REG_RD_DATA_I;
          next_is_load  = INSTR_I[BDTS_LOAD_BIT];
          next_wb       = INSTR_I[BDTS_WB_BIT];
          next_s_bit    = INSTR_I[BDTS_S_BIT];
          next_pc_in    = INSTR_I[BDTS_PC_IDX];
          next_base_in  = INSTR_I[INSTR_I[BDTS_BASE_HI:BDTS_BASE_LO]];
          next_instr_pc = INSTR_ADDR_I;
          next_first    = 1'b1;
          next_aborted  = 1'b0;
          // lowest address first in every mode
          if (INSTR_I[BDTS_UP_BIT])
          begin
            next_wb_val = REG_RD_DATA_I + n_bytes;
            next_addr   = INSTR_I[BDTS_PRE_BIT] ?
                          REG_RD_DATA_I + BDTS_WORD_STEP : REG_RD_DATA_I;
          end
          else
          begin
            next_wb_val = REG_RD_DATA_I - n_bytes;
            next_addr   = INSTR_I[BDTS_PRE_BIT] ? next_wb_val :
                          next_wb_val + BDTS_WORD_STEP;
          end
        end
      end
      BDTS_ADDR, BDTS_XFER:
      begin
        if (state == BDTS_XFER)
        begin
          next_first = 1'b0;
          next_addr  = addr + BDTS_WORD_STEP;
          if (MEM_ABORT_I)
          begin
            next_aborted = 1'b1;
          end
          next_ld_pend = is_load && !aborted && !MEM_ABORT_I;
          next_ld_data = MEM_RDATA_I;
          next_ld_idx  = xfer_idx;
        end
        if (low_found)
        begin
          // pick the next register and read it for the following cycle
          next_state    = BDTS_XFER;
          next_xfer_idx = low_idx;
          next_rlist    = rlist & ~(16'h0001 << low_idx);
          if (low_idx == BDTS_PC_IDX)
          begin
            next_wdata = instr_pc + BDTS_PC_STORE;
          end
          else if (state == BDTS_XFER && first && wb &&
                   low_idx == base_idx && !user_bank)
          begin
            next_wdata = wb_val;
          end
          else
          begin
            next_wdata = REG_RD_DATA_I;
          end
        end
        else if (is_load)
        begin
          next_state = BDTS_LAST;
        end
        else
        begin
          next_state = BDTS_IDLE;
          next_done  = 1'b1;
          next_trap  = aborted || MEM_ABORT_I;
        end
      end
      BDTS_LAST:
      begin
        if (ld_pend && ld_idx == BDTS_PC_IDX)
        begin
          next_state = BDTS_FILL1;
        end
        else
        begin
          next_state = BDTS_IDLE;
          next_done  = 1'b1;
          next_trap  = aborted;
        end
      end
      BDTS_FILL1:
      begin
        next_state = BDTS_FILL2;
      end
      BDTS_FILL2:
      begin
        next_state = BDTS_IDLE;
        next_done  = 1'b1;
      end
      default:
      begin
        next_state = BDTS_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state    <= BDTS_IDLE;
      rlist    <= BDTS_RLIST_RST;
      base_idx <= '0;
      base_val <= BDTS_WORD_RST;
      wb_val   <= BDTS_WORD_RST;
      addr     <= BDTS_WORD_RST;
      instr_pc <= BDTS_WORD_RST;
      wdata    <= BDTS_WORD_RST;
      ld_data  <= BDTS_WORD_RST;
      ld_idx   <= '0;
      xfer_idx <= '0;
      ld_pend  <= 1'b0;
      is_load  <= 1'b0;
      wb       <= 1'b0;
      s_bit    <= 1'b0;
      pc_in    <= 1'b0;
      base_in  <= 1'b0;
      first    <= 1'b0;
      aborted  <= 1'b0;
      done     <= 1'b0;
      trap     <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      rlist    <= next_rlist;
      base_idx <= next_base_idx;
      base_val <= next_base_val;
      wb_val   <= next_wb_val;
      addr     <= next_addr;
      instr_pc <= next_instr_pc;
      wdata    <= next_wdata;
      ld_data  <= next_ld_data;
      ld_idx   <= next_ld_idx;
      xfer_idx <= next_xfer_idx;
      ld_pend  <= next_ld_pend;
      is_load  <= next_is_load;
      wb       <= next_wb;
      s_bit    <= next_s_bit;
      pc_in    <= next_pc_in;
      base_in  <= next_base_in;
      first    <= next_first;
      aborted  <= next_aborted;
      done     <= next_done;
      trap     <= next_trap;
    end
  end

  // checks on the sequencing
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  a_cond_skip: assert property (
    state == BDTS_IDLE && INSTR_VALID_I && !COND_PASS_I |=>
      state == BDTS_IDLE && DONE_O && !REG_WR_EN_O)
    else $error("failed condition still started a transfer");
  a_order_rising: assert property (
    state == BDTS_XFER && $past(state) == BDTS_XFER |->
      xfer_idx > $past(xfer_idx))
    else $error("registers not moved in ascending order");
  a_addr_step: assert property (
    MEM_REQ_O && $past(MEM_REQ_O) |->
      MEM_ADDR_O == $past(MEM_ADDR_O) + BDTS_WORD_STEP && MEM_SEQ_O)
    else $error("transfer address did not step by one word");
  a_pc_stored: assert property (
    MEM_WRITE_O && xfer_idx == BDTS_PC_IDX |->
      MEM_WDATA_O == instr_pc + BDTS_PC_STORE)
    else $error("stored program counter value wrong");
  a_wb_cycle_two: assert property (
    state == BDTS_ADDR && wb ##1 state == BDTS_XFER |->
      REG_WR_EN_O && REG_WR_IDX_O == base_idx && REG_WR_DATA_O == wb_val)
    else $error("base not written back in the second cycle");
  a_store_no_wr: assert property (
    REG_WR_EN_O && !is_load |-> wb && first && state == BDTS_XFER)
    else $error("store wrote a register other than the base update");
  a_abort_stops: assert property (
    is_load && aborted && REG_WR_EN_O |-> REG_WR_IDX_O == base_idx)
    else $error("register written after a load abort");
  a_status_pc: assert property (
    STATUS_RESTORE_O |-> REG_WR_EN_O && REG_WR_IDX_O == BDTS_PC_IDX)
    else $error("status restored without a program counter load");
  a_user_store: assert property (
    BUSY_O && !is_load && s_bit && state != BDTS_IDLE |-> REG_RD_USER_O)
    else $error("store with bit 22 did not use the user bank");
  a_user_load: assert property (
    REG_WR_EN_O && is_load && s_bit && !pc_in && ld_pend |-> REG_WR_USER_O)
    else $error("load with bit 22 did not write the user bank");
  a_trap_end: assert property (
    MEM_REQ_O && MEM_ABORT_I |-> ##[1:20] (DATA_ABORT_O && DONE_O))
    else $error("abort did not end in the trap");

  c_store_abort: cover property (MEM_WRITE_O && MEM_ABORT_I);
  c_pc_restore: cover property (STATUS_RESTORE_O);
  c_load_abort: cover property (
    state == BDTS_LAST && aborted && base_in);
  c_base_forward: cover property (
    MEM_WRITE_O && xfer_idx == base_idx && !first && $past(first) && wb);

endmodule // bdts_sequencer

// File: tb/bdts_mem_model.sv
// memory system with memory manager facing the sequencer's memory port.
// assumes one transfer per MEM_REQ_O cycle, answered in that same cycle.
`timescale 1ns/1ps
module bdts_mem_model
(
  input  wire logic        clk_i,        // core clock
  input  wire logic        req_i,        // transfer cycle
  input  wire logic        write_i,      // 1 = store
  input  wire logic [31:0] addr_i,       // transfer address
  input  wire logic [31:0] wdata_i,      // store data
  output logic      [31:0] rdata_o,      // load data
  output logic             abort_o,      // address refused
  input  wire logic        abort_en_i,   // arm the refusal
  input  wire logic [31:0] abort_addr_i, // address to refuse
  input  wire logic [31:0] peek_addr_i,  // backdoor address
  output logic      [31:0] peek_data_o   // backdoor data
);
  logic [31:0] mem [2048];
  logic [31:0] last;

  // preset words hold a tag and their own address
  initial
  begin
    last = 32'h00000000;
    for (int i = 0; i < 2048; i++)
      mem[i] = 32'h5A000000 | 32'(i << 2);
  end

  // refuse one chosen address on any transfer
  assign abort_o = req_i && abort_en_i && (addr_i == abort_addr_i);
  // a released bus shows the inverse of its last word
  assign rdata_o = req_i ? mem[addr_i[12:2]] : ~last;
  assign peek_data_o = mem[peek_addr_i[12:2]];

  // refused stores never reach the array
  always @(posedge clk_i)
  begin
    if (req_i)
      last <= mem[addr_i[12:2]];
    if (req_i && write_i && !abort_o)
      mem[addr_i[12:2]] <= wdata_i;
  end
endmodule // bdts_mem_model

// File: tb/tb_block_data_transfer_sequencer.sv
// self-checking bench of the block transfer sequencer.
// assumes a register file model here and the memory model beside it.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_block_data_transfer_sequencer
  import bdts_pkg::*;
;
  logic clk, rst_n, valid, cond_pass, done, abort, stat, busy;
  logic rd_user, wr_en, wr_user, mem_req, mem_wr, mem_seq, m_abort, abort_en;
  logic [31:0] instr, iaddr, rd_data, wr_data, m_addr, m_wdata, m_rdata;
  logic [31:0] abort_addr, peek_a, peek_d, lo, wb, b, d, e;
  logic [3:0]  cond_f, rd_idx, wr_idx;
  logic [3:0]  ks [3];
  logic [31:0] rf [16];
  logic [31:0] uf [16];
  int miscompares, comparisons, cyc, n_req, n_nseq, n_stat, n_abort, n_busy;

  bdts_sequencer u_dut (.CLK_SYS_I(clk), .RSTN_I(rst_n),
    .INSTR_VALID_I(valid), .INSTR_I(instr), .INSTR_ADDR_I(iaddr),
    .COND_FIELD_O(cond_f), .COND_PASS_I(cond_pass), .BUSY_O(busy),
    .DONE_O(done), .DATA_ABORT_O(abort), .STATUS_RESTORE_O(stat),
    .REG_RD_IDX_O(rd_idx), .REG_RD_USER_O(rd_user), .REG_RD_DATA_I(rd_data),
    .REG_WR_EN_O(wr_en), .REG_WR_IDX_O(wr_idx), .REG_WR_USER_O(wr_user),
    .REG_WR_DATA_O(wr_data), .MEM_REQ_O(mem_req), .MEM_WRITE_O(mem_wr),
    .MEM_SEQ_O(mem_seq), .MEM_ADDR_O(m_addr), .MEM_WDATA_O(m_wdata),
    .MEM_RDATA_I(m_rdata), .MEM_ABORT_I(m_abort));

  bdts_mem_model u_mem (.clk_i(clk), .req_i(mem_req), .write_i(mem_wr),
    .addr_i(m_addr), .wdata_i(m_wdata), .rdata_o(m_rdata),
    .abort_o(m_abort), .abort_en_i(abort_en), .abort_addr_i(abort_addr),
    .peek_addr_i(peek_a), .peek_data_o(peek_d));

  // register file: current and user banks, write seen next cycle
  assign rd_data = rd_user ? uf[rd_idx] : rf[rd_idx];
  always @(posedge clk)
  begin
    if (wr_en === 1'b1)
    begin
      if (wr_user)
        uf[wr_idx] <= wr_data;
      else
        rf[wr_idx] <= wr_data;
    end
  end

  // pulse and transfer counters, sampled mid-cycle
  always @(negedge clk)
  begin
    n_req   += int'(mem_req === 1'b1);
    n_nseq  += int'(mem_req === 1'b1 && mem_seq === 1'b0);
    n_stat  += int'(stat === 1'b1);
    n_abort += int'(abort === 1'b1);
    n_busy  += int'(busy === 1'b1);
  end

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] mk(input logic [4:0] puswl,
                                     input logic [3:0] bi,
                                     input logic [15:0] lst);
    mk = {4'hE, 3'h4, puswl, bi, lst};
  endfunction

  function automatic logic [31:0] pat(input logic [31:0] a);
    pat = 32'h5A000000 | {19'h0, a[12:0]};
  endfunction

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // offer one instruction, count cycles until the done pulse
  task automatic run(input logic [31:0] ins, input logic cp);
    @(posedge clk);
    n_req = 0; n_nseq = 0; n_stat = 0; n_abort = 0; n_busy = 0;
    instr <= ins;
    cond_pass <= cp;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    cyc = 0;
    for (int k = 1; k <= 40 && cyc == 0; k++)
    begin
      @(negedge clk);
      if (done === 1'b1)
        cyc = k;
    end
    #1;
    if (cyc == 0)
    begin
      miscompares++;
      $display("Error done expected 1 seen 0");
      conclude();
    end
  endtask

  task automatic peek(input logic [31:0] a, output logic [31:0] v);
    peek_a = a;
    #1;
    v = peek_d;
  endtask

  // main sequence
  initial
  begin
    rst_n = 1'b0; valid = 1'b0; cond_pass = 1'b0; abort_en = 1'b0;
    instr = 32'h0; iaddr = 32'h300; abort_addr = 32'h0; peek_a = 32'h0;
    ks = '{4'h1, 4'h5, 4'h7};
    for (int i = 0; i < 16; i++)
    begin
      rf[i] = 32'h11110000 | i;
      uf[i] = 32'h22220000 | i;
    end
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // all four addressing modes, store then load of three words
    for (int l = 0; l < 2; l++)
      for (int m = 0; m < 4; m++)
      begin
        b = l ? 32'h800 : 32'h1000;
        rf[0] = b;
        for (int j = 0; j < 3; j++)
          rf[ks[j]] = {24'h0, 4'(m), ks[j]};
        lo = m[0] ? (m[1] ? b + 4 : b) : (m[1] ? b - 12 : b - 8);
        wb = m[0] ? b + 12 : b - 12;
        run(mk({m[1], m[0], 2'b01, 1'(l)}, 4'h0, 16'h00A2), 1'b1);
        `CHK("cycles", l ? 6 : 5, cyc)
        `CHK("nonseq", 1, n_nseq)
        `CHK("busy", l ? 5 : 4, n_busy)
        `CHK("no trap", 0, n_abort)
        `CHK("base wb", wb, rf[0])
        for (int j = 0; j < 3; j++)
        begin
          peek(lo + 32'(4 * j), d);
          e = {24'h0, 4'(m), ks[j]};
          if (l) `CHK("load word", pat(lo + 32'(4 * j)), rf[ks[j]])
          else `CHK("store word", e, d)
        end
      end
    // failed condition: no transfer, base kept
    rf[0] = 32'h1000;
    run(mk(5'h0B, 4'h0, 16'h0002), 1'b0);
    `CHK("cond field", 4'hE, cond_f)
    `CHK("skip busy", 0, n_busy)
    `CHK("skip cycles", 1, cyc)
    `CHK("skip xfers", 0, n_req)
    `CHK("skip base", 32'h1000, rf[0])
    // base stored first keeps old value, stored second the new one
    rf[3] = 32'h1000;
    rf[4] = 32'h1000;
    run(mk(5'h0A, 4'h3, 16'h0018), 1'b1);
    peek(32'h1000, d);
    `CHK("base first", 32'h1000, d)
    run(mk(5'h0A, 4'h4, 16'h0018), 1'b1);
    peek(32'h1004, d);
    `CHK("base second", 32'h1008, d)
    // no write-back leaves the base alone
    rf[4] = 32'h1000;
    run(mk(5'h08, 4'h4, 16'h0002), 1'b1);
    `CHK("base kept", 32'h1000, rf[4])
    // loaded base beats the written-back address
    rf[2] = 32'h800;
    run(mk(5'h0B, 4'h2, 16'h000C), 1'b1);
    `CHK("base loaded", pat(32'h800), rf[2])
    `CHK("next load", pat(32'h804), rf[3])
    // user bank store with program counter
    rf[0] = 32'h1000;
    run(mk(5'h0C, 4'h0, 16'h8002), 1'b1);
    peek(32'h1000, d);
    `CHK("user store", 32'h22220001, d)
    peek(32'h1004, d);
    `CHK("pc stored", 32'h30C, d)
    // user bank load without program counter
    rf[0] = 32'h800;
    e = rf[2];
    run(mk(5'h0D, 4'h0, 16'h0004), 1'b1);
    `CHK("user load", pat(32'h800), uf[2])
    `CHK("bank kept", e, rf[2])
    // program counter load with status restore
    run(mk(5'h0D, 4'h0, 16'h8002), 1'b1);
    `CHK("pc cycles", 7, cyc)
    `CHK("restore", 1, n_stat)
    `CHK("pc load", pat(32'h804), rf[15])
    // refused store word: finish, trap, base still updated
    rf[0] = 32'h1000;
    peek(32'h1004, e);
    abort_en = 1'b1;
    abort_addr = 32'h1004;
    run(mk(5'h0A, 4'h0, 16'h00A2), 1'b1);
    `CHK("st ab cyc", 5, cyc)
    `CHK("st ab trap", 1, n_abort)
    `CHK("st ab base", 32'h100C, rf[0])
    peek(32'h1004, d);
    `CHK("st ab blocked", e, d)
    peek(32'h1008, d);
    `CHK("st ab last", rf[7], d)
    // refused load word: later writes stop, base restored
    rf[1] = 32'h800;
    rf[2] = 32'hBEEF0002;
    rf[15] = 32'hBEEF000F;
    abort_addr = 32'h804;
    run(mk(5'h0B, 4'h1, 16'h8007), 1'b1);
    abort_en = 1'b0;
    `CHK("ld ab early", pat(32'h800), rf[0])
    `CHK("ld ab base", 32'h810, rf[1])
    `CHK("ld ab later", 32'hBEEF0002, rf[2])
    `CHK("ld ab pc", 32'hBEEF000F, rf[15])
    `CHK("ld ab trap", 1, n_abort)
    conclude();
  end
endmodule // tb_block_data_transfer_sequencer
